// ---- design/xl_ipr_consts.svh ----
// Constants for the fetch-unit translation and exception register group.
// Assumes the pipeline presents internal register moves by index on one port.
//
// Operation
// - Space id register is read/write, field bits 10 down to 4.
// - Entry read loads holding register; holding read delivers data to integer file.
// - Holding bits 29..31 are thermometer code of the two-bit page size hint.
// - Write to invalidate-nonglobal drops every entry whose global bit is zero.
// - Write to invalidate-everything drops all entries and resets replacement pointer.
// - Invalidate-single drops entry matching VA 42:13 and space id or global.
// - Miss or access fault, not sign-check, loads formatted fault address by mode.
// - Page table base is read/write; bits 32:30 undefined in non-NT mode.
// - Parity status bits 11,12,13 record data, tag, timeout faults; write one clears.
// - Any write to flush trigger invalidates whole instruction cache.
// - Return address written by software and hardware; exception write wins; trap return resumes.
// - Captured address: faulting PC, next-issue PC, or PC after privileged call.
// - Return address bit 0 holds privileged mode; trap return takes mode from it.
// - Summary accumulates arithmetic traps; any write clears bits 16 through 10.
// - Summary flags sit at bits 11 to 16 in the documented order.
// - Completion flag sets while all floating traps had qualifier; unqualified floating trap clears until write.
// - Destination mask records one bit per destination register of each trap.
// - Any summary write also clears the whole destination mask.
// - Privileged code base is read/write and cleared by reset.
// - Each entry write advances the replacement pointer.
// - NT superpage enable selects alternate fault address format; table base keeps bits 63:30 in both modes.
`ifndef XL_IPR_CONSTS_SVH
`define XL_IPR_CONSTS_SVH

// Register indices
`define XL_IDX_PAGE_TABLE_BASE 16'h0113
`define XL_IDX_FAULT_FORM 16'h0112
`define XL_IDX_FLUSH 16'h0119
`define XL_IDX_PARITY_STAT 16'h011A
`define XL_IDX_MASK 16'h010D
`define XL_IDX_CODE_BASE 16'h010E
`define XL_IDX_SPACE_ID 16'h0120
`define XL_IDX_ENTRY 16'h0121
`define XL_IDX_HOLD 16'h0122
`define XL_IDX_INV_NONGLOBAL 16'h0123
`define XL_IDX_INV_ALL 16'h0124
`define XL_IDX_INV_SINGLE 16'h0125
`define XL_IDX_RET_ADDR 16'h0126
`define XL_IDX_SUMMARY 16'h0127

// Field positions
`define XL_ASN_LO 4
`define XL_ASN_HI 10
`define XL_HINT_LO 29
`define XL_PERR_LO 11
`define XL_SUM_LO 10
`define XL_VA_LO 13
`define XL_VA_HI 42
`define XL_PTB_LO 30
`define XL_PTB_NONNT_LO 33
`define XL_NT_VA_HI 31
`define XL_PTR_W 6
`define XL_ZERO64 64'h0000_0000_0000_0000
`define XL_PTR_ZERO 6'h00
`define XL_PTR_ONE 6'h01
`define XL_PTB_W 34
`define XL_NT_GAP 8'h00
`define XL_FORM_PAD 3'h0
`define XL_SUM_CLR 7'h00

`endif

// ---- design/xl_ipr_pkg.sv ----
// Types for the fetch-unit translation and exception register group.
// Assumes the constants header is on the include path.
`include "xl_ipr_consts.svh"
package xl_ipr_pkg;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] idx;
    logic [63:0] wdata;
  } xl_ipr_req_s;

  typedef struct packed {
    logic miss;
    logic acc_fault;
    logic sign_err;
    logic [42:0] va;
  } xl_fault_s;

  typedef struct packed {
    logic valid;
    logic is_fp;
    logic swc_qual;
    logic [5:0] flags;
    logic dest_int;
    logic [4:0] dest_reg;
  } xl_trap_s;

  typedef struct packed {
    logic take;
    logic precise;
    logic [63:0] fault_pc;
    logic [63:0] next_pc;
    logic call_take;
    logic [63:0] call_next_pc;
    logic cur_priv;
    logic rei;
  } xl_exc_s;

  typedef struct packed {
    logic inv_all;
    logic inv_nonglobal;
    logic inv_single;
    logic [29:0] inv_va;
    logic [6:0] inv_asn;
    logic fill;
    logic [`XL_PTR_W-1:0] fill_idx;
    logic [63:0] fill_pte;
  } xl_tb_cmd_s;

endpackage : xl_ipr_pkg

// ---- design/xl_ipr_bank.sv ----
// Fetch-unit register group: translation buffer upkeep, fault address, parity
// status, cache flush and exception state. The buffer array lives outside and
// obeys the command struct; all other inputs come from logic on the same clock.
// Event outputs stand for one cycle; stored values hold until changed.
module xl_ipr_bank
  import xl_ipr_pkg::*;
#(
  parameter int TB_ENTRIES = 48
) (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire xl_ipr_req_s i_ipr,
  input wire logic i_nt_superpage_enable,
  input wire logic [63:0] i_tb_entry_pte,
  input wire logic [1:0] i_tb_entry_hint,
  input wire xl_fault_s i_fault,
  input wire logic i_ic_data_perr,
  input wire logic i_ic_tag_perr,
  input wire logic i_timeout_err,
  input wire xl_trap_s i_trap,
  input wire xl_exc_s i_exc,
  output logic [63:0] o_ipr_rdata,
  output logic o_ipr_rvalid,
  output logic [`XL_PTR_W-1:0] o_tb_ptr,
  output xl_tb_cmd_s o_tb_cmd,
  output logic o_ic_flush,
  output logic [63:0] o_resume_pc,
  output logic o_resume_priv,
  output logic o_resume_valid,
  output logic [6:0] o_space_id
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  // One packed word holds every register, so one always_ff updates them all
  typedef struct packed {
    logic [6:0] process_space_id;
    logic [`XL_PTR_W-1:0] ptr;
    logic [63:0] hold;
    logic [63:0] fault_form;
    logic [33:0] ptbr;
    logic [2:0] perr;
    logic [63:0] exception_return_address_reg;
    logic [6:0] sum;
    logic swc_blocked;
    logic [63:0] mask;
    logic [63:0] code_base;
    logic [63:0] rdata;
    logic rvalid;
    logic flush;
    xl_tb_cmd_s cmd;
    logic [63:0] resume_pc;
    logic resume_priv;
    logic resume_valid;
  } xl_state_s;

  xl_state_s st_r;
  xl_state_s st_nxt;

  // Index compare shared by every write strobe and the read mux
  function automatic logic hit(input logic [15:0] idx, input logic [15:0] ref_idx);
    hit = (idx == ref_idx);
  endfunction : hit

  // Wrapping pointer step
  // Wraps after the last slot so successive fills visit every entry
  function automatic logic [`XL_PTR_W-1:0] ptr_after(input logic [`XL_PTR_W-1:0] ptr,
                                                     input logic [`XL_PTR_W-1:0] last);
    ptr_after = (ptr == last) ? `XL_PTR_ZERO : ptr + `XL_PTR_ONE;
  endfunction : ptr_after

  // Destination bit mapping
  // Float register n is bit n, integer register n is bit 32+n
  function automatic logic [63:0] dest_onehot(input logic is_int, input logic [4:0] reg_no);
    dest_onehot = `XL_ZERO64;
    dest_onehot[{is_int, reg_no}] = 1'b1;
  endfunction : dest_onehot

  // Last slot in use; a smaller buffer never sees the upper pointer values
  logic [`XL_PTR_W-1:0] last_ptr;
  assign last_ptr = `XL_PTR_W'(TB_ENTRIES - 1);

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic wr;
    logic rd;
    logic [2:0] perr_set;
    logic [63:0] dest_bit;
    logic [2:0] therm;
    wr = i_ipr.wr;
    rd = i_ipr.rd;
    st_nxt = st_r;
    // Event outputs fall back to zero so each stands exactly one cycle
    st_nxt.rvalid = 1'b0;
    st_nxt.rdata = `XL_ZERO64;
    st_nxt.flush = 1'b0;
    st_nxt.resume_valid = 1'b0;
    st_nxt.cmd.inv_all = 1'b0;
    st_nxt.cmd.inv_nonglobal = 1'b0;
    st_nxt.cmd.inv_single = 1'b0;
    st_nxt.cmd.fill = 1'b0;
    perr_set = {i_timeout_err, i_ic_tag_perr, i_ic_data_perr};
    dest_bit = dest_onehot(i_trap.dest_int, i_trap.dest_reg);
    therm = {i_tb_entry_hint == 2'b11, i_tb_entry_hint[1], i_tb_entry_hint != 2'b00};

    // ----------------------------------------------------------
    // Translation buffer upkeep
    // ----------------------------------------------------------
    // Space id store
    if (wr && hit(i_ipr.idx, `XL_IDX_SPACE_ID)) begin
      st_nxt.process_space_id = i_ipr.wdata[`XL_ASN_HI:`XL_ASN_LO];
    end

    if (wr && hit(i_ipr.idx, `XL_IDX_ENTRY)) begin
      st_nxt.cmd.fill = 1'b1;
      st_nxt.cmd.fill_idx = st_r.ptr;
      st_nxt.cmd.fill_pte = i_ipr.wdata;
      // The array writes the old slot on the next edge
      st_nxt.ptr = ptr_after(st_r.ptr, last_ptr);
    end

    // Entry read into holding register, pointer advances too
    if (rd && hit(i_ipr.idx, `XL_IDX_ENTRY)) begin
      st_nxt.hold = i_tb_entry_pte;
      st_nxt.hold[`XL_HINT_LO +: 3] = therm;
      // The entry read itself answers zero; the data waits in the hold register
      st_nxt.ptr = ptr_after(st_r.ptr, last_ptr);
    end

    if (wr && hit(i_ipr.idx, `XL_IDX_INV_NONGLOBAL)) begin
      st_nxt.cmd.inv_nonglobal = 1'b1;
      st_nxt.cmd.inv_asn = st_r.process_space_id;
    end

    if (wr && hit(i_ipr.idx, `XL_IDX_INV_ALL)) begin
      st_nxt.cmd.inv_all = 1'b1;
      // The only write that brings the pointer home from any slot
      st_nxt.ptr = `XL_PTR_ZERO;
    end

    // Single-entry drop by VA and space id
    if (wr && hit(i_ipr.idx, `XL_IDX_INV_SINGLE)) begin
      // The array drops a VA match that has this space id or the global bit
      st_nxt.cmd.inv_single = 1'b1;
      st_nxt.cmd.inv_va = i_ipr.wdata[`XL_VA_HI:`XL_VA_LO];
      st_nxt.cmd.inv_asn = st_r.process_space_id;
    end

    // ----------------------------------------------------------
    // Fault address and table base
    // ----------------------------------------------------------
    // Table base keeps bits 63:30 in both modes
    if (wr && hit(i_ipr.idx, `XL_IDX_PAGE_TABLE_BASE)) begin
      st_nxt.ptbr = i_ipr.wdata[63:`XL_PTB_LO];
    end

    // Fault address capture; sign-check faults leave it alone
    if (i_fault.miss || (i_fault.acc_fault && !i_fault.sign_err)) begin
      // Alternate format in NT superpage mode
      if (i_nt_superpage_enable) begin
        // NT mode keeps the whole base and only VA 31:13
        st_nxt.fault_form = {st_r.ptbr, `XL_NT_GAP, i_fault.va[`XL_NT_VA_HI:`XL_VA_LO],
                             `XL_FORM_PAD};
      end else begin
        // Non-NT mode gives base bits 32:30 up to the wider VA field
        st_nxt.fault_form = {st_r.ptbr[`XL_PTB_W-1:`XL_PTB_NONNT_LO-`XL_PTB_LO],
                             i_fault.va[`XL_VA_HI:`XL_VA_LO], `XL_FORM_PAD};
      end
    end

    // ----------------------------------------------------------
    // Parity status and cache flush
    // ----------------------------------------------------------
    // Write-one clear, then new faults
    if (wr && hit(i_ipr.idx, `XL_IDX_PARITY_STAT)) begin
      st_nxt.perr = st_r.perr & ~i_ipr.wdata[`XL_PERR_LO +: 3];
    end
    // Fault set wins
    // A fault in the clearing cycle survives, so no event is lost
    st_nxt.perr = st_nxt.perr | perr_set;

    if (wr && hit(i_ipr.idx, `XL_IDX_FLUSH)) begin
      // Pulse only; the cache itself does the clearing
      st_nxt.flush = 1'b1;
    end

    // ----------------------------------------------------------
    // Code base and exception address
    // ----------------------------------------------------------
    // Code base store
    if (wr && hit(i_ipr.idx, `XL_IDX_CODE_BASE)) begin
      st_nxt.code_base = i_ipr.wdata;
    end

    // Software write below call, exception above all
    // Later assignments win, so the order below is the priority order
    if (wr && hit(i_ipr.idx, `XL_IDX_RET_ADDR)) begin
      st_nxt.exception_return_address_reg = i_ipr.wdata;
    end
    if (i_exc.call_take) begin
      st_nxt.exception_return_address_reg = {i_exc.call_next_pc[63:1], i_exc.cur_priv};
    end
    if (i_exc.take) begin
      st_nxt.exception_return_address_reg[63:1] = i_exc.precise ? i_exc.fault_pc[63:1] : i_exc.next_pc[63:1];
      st_nxt.exception_return_address_reg[0] = i_exc.cur_priv;
    end
    // Trap return takes address and mode
    // Bit 0 carries the mode, so it never reaches the resume address
    if (i_exc.rei) begin
      st_nxt.resume_valid = 1'b1;
      st_nxt.resume_pc = {st_r.exception_return_address_reg[63:1], 1'b0};
      st_nxt.resume_priv = st_r.exception_return_address_reg[0];
    end

    // ----------------------------------------------------------
    // Trap summary and mask
    // ----------------------------------------------------------
    // Summary write clears flags
    if (wr && hit(i_ipr.idx, `XL_IDX_SUMMARY)) begin
      st_nxt.sum = `XL_SUM_CLR;
      st_nxt.swc_blocked = 1'b0;
      st_nxt.mask = `XL_ZERO64;
    end
    if (wr && hit(i_ipr.idx, `XL_IDX_MASK)) begin
      st_nxt.mask = i_ipr.wdata;
    end
    // Trap accumulates after any clear
    // Clears above come first, so a trap in the same cycle is kept
    if (i_trap.valid) begin
      st_nxt.sum[6:1] = st_nxt.sum[6:1] | i_trap.flags;
      st_nxt.mask = st_nxt.mask | dest_bit;
      // Completion flag tracking
      // Non-floating traps leave the completion flag as it is
      if (i_trap.is_fp && i_trap.swc_qual && !st_nxt.swc_blocked) begin
        st_nxt.sum[0] = 1'b1;
      end else if (i_trap.is_fp && !i_trap.swc_qual) begin
        st_nxt.sum[0] = 1'b0;
        st_nxt.swc_blocked = 1'b1;
      end
    end

    // ----------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------
    // Write-only and unknown indices answer zero; a read sees the state
    // before a write of the same cycle
    if (rd) begin
      st_nxt.rvalid = 1'b1;
      case (1'b1)
        hit(i_ipr.idx, `XL_IDX_SPACE_ID): st_nxt.rdata[`XL_ASN_HI:`XL_ASN_LO] = st_r.process_space_id;
        hit(i_ipr.idx, `XL_IDX_HOLD): st_nxt.rdata = st_r.hold;
        hit(i_ipr.idx, `XL_IDX_FAULT_FORM): st_nxt.rdata = st_r.fault_form;
        hit(i_ipr.idx, `XL_IDX_PAGE_TABLE_BASE): st_nxt.rdata[63:`XL_PTB_LO] = st_r.ptbr;
        hit(i_ipr.idx, `XL_IDX_PARITY_STAT): st_nxt.rdata[`XL_PERR_LO +: 3] = st_r.perr;
        hit(i_ipr.idx, `XL_IDX_RET_ADDR): st_nxt.rdata = st_r.exception_return_address_reg;
        hit(i_ipr.idx, `XL_IDX_SUMMARY): st_nxt.rdata[`XL_SUM_LO +: 7] = st_r.sum;
        hit(i_ipr.idx, `XL_IDX_MASK): st_nxt.rdata = st_r.mask;
        hit(i_ipr.idx, `XL_IDX_CODE_BASE): st_nxt.rdata = st_r.code_base;
        default: st_nxt.rdata = `XL_ZERO64;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  // Pointer resets to zero here as well, so it is defined even if reset
  // software forgets its invalidate-everything write.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      // Code base cleared with everything else
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Every output is a field of the state register, none is combinational
  assign o_ipr_rdata = st_r.rdata;
  assign o_ipr_rvalid = st_r.rvalid;
  assign o_tb_ptr = st_r.ptr;
  assign o_tb_cmd = st_r.cmd;
  assign o_ic_flush = st_r.flush;
  assign o_resume_pc = st_r.resume_pc;
  assign o_resume_priv = st_r.resume_priv;
  assign o_resume_valid = st_r.resume_valid;
  assign o_space_id = st_r.process_space_id;

endmodule : xl_ipr_bank

// ---- testbench/xl_tb_array.sv ----
// Entry array model standing beside the register group.
// Assumes commands arrive as one-cycle pulses on the group's clock.
`include "xl_ipr_consts.svh"
module xl_tb_array
  import xl_ipr_pkg::*;
(
  input wire logic i_clk_sys,
  input wire xl_tb_cmd_s i_cmd,
  input wire logic [`XL_PTR_W-1:0] i_ptr,
  output logic [63:0] o_pte,
  output logic [1:0] o_hint
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [63:0] mem [64];
  logic [63:0] vld = '0;
  // Dead slots toggle so a stale value never passes for data
  assign o_pte = vld[i_ptr] ? mem[i_ptr] : {32{i_clk_sys, !i_clk_sys}};
  assign o_hint = o_pte[6:5];
  always @(posedge i_clk_sys) begin
    for (int k = 0; k < 64; k++) begin
      if (i_cmd.inv_all || (i_cmd.inv_nonglobal && !mem[k][4])) vld[k] <= 1'b0;
    end
    if (i_cmd.fill) begin
      mem[i_cmd.fill_idx] <= i_cmd.fill_pte;
      vld[i_cmd.fill_idx] <= 1'b1;
    end
  end
endmodule : xl_tb_array

// ---- testbench/xl_ipr_bank_sva.sv ----
// Port checker for the fetch-unit register group.
// Assumes one clock and a synchronous active-high reset.
`include "xl_ipr_consts.svh"
module xl_ipr_bank_sva
  import xl_ipr_pkg::*;
#(
  parameter int TB_ENTRIES = 48
) (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire xl_ipr_req_s i_ipr,
  input wire xl_exc_s i_exc,
  input wire logic o_ipr_rvalid,
  input wire logic [`XL_PTR_W-1:0] o_tb_ptr,
  input wire xl_tb_cmd_s o_tb_cmd,
  input wire logic o_ic_flush,
  input wire logic o_resume_valid,
  input wire logic [63:0] o_resume_pc,
  input wire logic [6:0] o_space_id
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  logic [15:0] ix;
  logic [29:0] va;
  logic [6:0] sid;
  assign ix = i_ipr.idx;
  assign va = i_ipr.wdata[42:13];
  assign sid = i_ipr.wdata[10:4];
  sequence fill_s;
    o_tb_cmd.fill && o_tb_cmd.fill_pte == $past(i_ipr.wdata)
      && o_tb_cmd.fill_idx == $past(o_tb_ptr);
  endsequence
  sequence step_s;
    o_tb_ptr == (($past(o_tb_ptr) == TB_ENTRIES - 1) ? '0 : $past(o_tb_ptr) + 1'b1);
  endsequence
  rd_answer_a: assert property (i_ipr.rd |=> o_ipr_rvalid)
    else $error("read not answered");
  ptr_step_a: assert property ((i_ipr.rd ^ i_ipr.wr) && ix == `XL_IDX_ENTRY |=> step_s)
    else $error("pointer did not step");
  fill_cmd_a: assert property (i_ipr.wr && ix == `XL_IDX_ENTRY |=> fill_s)
    else $error("fill command wrong");
  inv_all_a: assert property (i_ipr.wr && ix == `XL_IDX_INV_ALL |=> o_tb_cmd.inv_all
    && o_tb_ptr == '0)
    else $error("invalidate all wrong");
  inv_ng_a: assert property (i_ipr.wr && ix == `XL_IDX_INV_NONGLOBAL
    |=> o_tb_cmd.inv_nonglobal)
    else $error("nonglobal invalidate missing");
  inv_one_a: assert property (i_ipr.wr && ix == `XL_IDX_INV_SINGLE |=> o_tb_cmd.inv_single
    && o_tb_cmd.inv_va == $past(va) && o_tb_cmd.inv_asn == o_space_id)
    else $error("single invalidate wrong");
  cache_flush_a: assert property (i_ipr.wr && ix == `XL_IDX_FLUSH |=> o_ic_flush)
    else $error("flush missing");
  space_id_a: assert property (i_ipr.wr && ix == `XL_IDX_SPACE_ID
    |=> o_space_id == $past(sid))
    else $error("space id not stored");
  trap_resume_a: assert property (i_exc.rei |=> o_resume_valid && !o_resume_pc[0])
    else $error("trap return wrong");
endmodule : xl_ipr_bank_sva
bind xl_ipr_bank xl_ipr_bank_sva #(.TB_ENTRIES(TB_ENTRIES)) xl_ipr_bank_sva_i (
  .i_clk_sys, .i_srst, .i_ipr, .i_exc, .o_ipr_rvalid, .o_tb_ptr, .o_tb_cmd,
  .o_ic_flush, .o_resume_valid, .o_resume_pc, .o_space_id
);

// ---- testbench/tb.sv ----
// Self-checking bench for the fetch-unit register group and its entry array model.
// Assumes all parts share one 10 MHz clock.
`include "xl_ipr_consts.svh"
module tb
  import xl_ipr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {xl_fault_s f; xl_trap_s t; xl_exc_s x; logic [2:0] p;} xl_side_s;
  localparam int N = 4;
  logic i_clk_sys = 1'b0;
  logic i_srst = 1'b1;
  logic i_nt_superpage_enable = 1'b0;
  xl_ipr_req_s i_ipr = '0;
  xl_side_s sd = '0, ps = '0;
  logic [63:0] i_tb_entry_pte, o_ipr_rdata, o_resume_pc, v, m_ptb, m_sum = '0, m_msk = '0;
  logic [1:0] i_tb_entry_hint;
  logic [63:0] pte_q [$];
  logic o_ipr_rvalid, o_ic_flush, o_resume_priv, o_resume_valid;
  logic [`XL_PTR_W-1:0] o_tb_ptr;
  xl_tb_cmd_s o_tb_cmd;
  logic [6:0] o_space_id;
  logic [31:0] seed = 32'h3acc_32a6;
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  always #50 i_clk_sys = !i_clk_sys;
  xl_ipr_bank #(.TB_ENTRIES(N)) xl_ipr_bank_i (
    .i_clk_sys, .i_srst, .i_ipr, .i_nt_superpage_enable, .i_tb_entry_pte, .i_tb_entry_hint,
    .i_fault(sd.f), .i_ic_data_perr(sd.p[0]), .i_ic_tag_perr(sd.p[1]), .i_timeout_err(sd.p[2]),
    .i_trap(sd.t), .i_exc(sd.x), .o_ipr_rdata, .o_ipr_rvalid, .o_tb_ptr, .o_tb_cmd,
    .o_ic_flush, .o_resume_pc, .o_resume_priv, .o_resume_valid, .o_space_id
  );
  xl_tb_array xl_tb_array_i (
    .i_clk_sys, .i_cmd(o_tb_cmd), .i_ptr(o_tb_ptr), .o_pte(i_tb_entry_pte),
    .o_hint(i_tb_entry_hint)
  );
  function automatic logic [63:0] rnd();
    logic [63:0] r;
    for (int k = 0; k < 64; k++) begin
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      r = {r[62:0], seed[0]};
    end
    return r;
  endfunction : rnd
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    $display("mismatches %0d of %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  // One move plus pending side events; a read is compared under a mask
  task automatic ipr(input logic rd, input logic wr, input logic [15:0] ix,
                     input logic [63:0] d, input logic [63:0] e = '0, input logic [63:0] m = '1);
    @(posedge i_clk_sys);
    i_ipr <= '{rd, wr, ix, d};
    sd <= ps;
    ps = '0;
    @(posedge i_clk_sys);
    i_ipr <= '0;
    sd <= '0;
    #1;
    chk({63'h0, o_ipr_rvalid}, {63'h0, rd});
    if (rd) chk(o_ipr_rdata & m, e & m);
  endtask : ipr
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    repeat (5) @(posedge i_clk_sys);
    i_srst <= 1'b0;
    ipr(1, 0, `XL_IDX_CODE_BASE, '0, '0);
    ipr(1, 0, 16'h0000, '0, '0);
    ipr(0, 1, `XL_IDX_INV_ALL, '0);
    v = rnd();
    m_ptb = rnd();
    ipr(0, 1, `XL_IDX_SPACE_ID, v);
    ipr(1, 0, `XL_IDX_SPACE_ID, '0, v & 64'h0000_0000_0000_07F0);
    ipr(0, 1, `XL_IDX_CODE_BASE, v);
    ipr(1, 0, `XL_IDX_CODE_BASE, '0, v);
    ipr(0, 1, `XL_IDX_PAGE_TABLE_BASE, m_ptb);
    ipr(1, 0, `XL_IDX_PAGE_TABLE_BASE, '0, m_ptb, 64'hFFFF_FFFE_0000_0000);
    for (int k = 0; k < N; k++) begin
      v = rnd();
      v[6:5] = k[1:0];
      pte_q.push_back(v);
      ipr(0, 1, `XL_IDX_ENTRY, v);
    end
    chk(64'(o_tb_ptr), '0);
    for (int k = 0; k < N; k++) begin
      ipr(1, 0, `XL_IDX_ENTRY, '0, '0);
      v = pte_q.pop_front();
      v[31:29] = {k == 3, k > 1, k > 0};
      ipr(1, 0, `XL_IDX_HOLD, '0, v);
    end
    v = rnd();
    ps.f = '{1'b1, 1'b0, 1'b0, v[42:0]};
    ipr(0, 0, '0, '0);
    ipr(1, 0, `XL_IDX_FAULT_FORM, '0, {m_ptb[63:33], v[42:13], 3'h0});
    i_nt_superpage_enable <= 1'b1;
    ps.f = '{1'b0, 1'b1, 1'b0, v[42:0]};
    ipr(0, 0, '0, '0);
    ps.f = '{1'b0, 1'b1, 1'b1, ~v[42:0]};
    ipr(0, 0, '0, '0);
    ipr(1, 0, `XL_IDX_FAULT_FORM, '0, {m_ptb[63:30], 8'h00, v[31:13], 3'h0});
    ipr(1, 0, `XL_IDX_PAGE_TABLE_BASE, '0, m_ptb, 64'hFFFF_FFFF_C000_0000);
    ps.p = 3'b111;
    ipr(0, 0, '0, '0);
    ipr(1, 0, `XL_IDX_PARITY_STAT, '0, 64'h0000_0000_0000_3800);
    ps.p = 3'b001;
    ipr(0, 1, `XL_IDX_PARITY_STAT, 64'h0000_0000_0000_1800);
    ipr(1, 0, `XL_IDX_PARITY_STAT, '0, 64'h0000_0000_0000_2800);
    for (int k = 0; k < 3; k++) begin
      v = rnd();
      ps.t = '{1'b1, k < 2, k == 0, v[5:0], k == 2, v[10:6]};
      m_sum[16:11] |= v[5:0];
      m_sum[10] = (k == 0);
      m_msk[{k == 2, v[10:6]}] = 1'b1;
      ipr(0, 0, '0, '0);
      ipr(1, 0, `XL_IDX_SUMMARY, '0, m_sum, 64'h0000_0000_0001_FC00);
      ipr(1, 0, `XL_IDX_MASK, '0, m_msk);
    end
    ipr(0, 1, `XL_IDX_SUMMARY, '1);
    ipr(1, 0, `XL_IDX_SUMMARY, '0, '0, 64'h0000_0000_0001_FC00);
    ipr(1, 0, `XL_IDX_MASK, '0, '0);
    v = rnd();
    ps.x = '{1'b1, 1'b1, v, ~v, 1'b0, '0, 1'b1, 1'b0};
    ipr(0, 1, `XL_IDX_RET_ADDR, rnd());
    ipr(1, 0, `XL_IDX_RET_ADDR, '0, {v[63:1], 1'b1});
    ps.x = '{1'b1, 1'b0, v, ~v, 1'b0, '0, 1'b0, 1'b0};
    ipr(0, 0, '0, '0);
    ipr(1, 0, `XL_IDX_RET_ADDR, '0, {~v[63:1], 1'b0});
    ps.x = '{1'b0, 1'b0, '0, '0, 1'b1, v, 1'b1, 1'b0};
    ipr(0, 0, '0, '0);
    ps.x.rei = 1'b1;
    ipr(0, 0, '0, '0);
    chk({o_resume_pc[63:1], o_resume_priv}, {v[63:1], 1'b1});
    chk({63'h0, o_resume_valid}, {63'h0, 1'b1});
    ipr(0, 1, `XL_IDX_INV_NONGLOBAL, '0);
    v = rnd();
    ipr(0, 1, `XL_IDX_INV_SINGLE, v);
    chk(64'({o_tb_cmd.inv_single, o_tb_cmd.inv_va}), 64'({1'b1, v[42:13]}));
    ipr(0, 1, `XL_IDX_FLUSH, rnd());
    chk({63'h0, o_ic_flush}, {63'h0, 1'b1});
    ipr(0, 1, `XL_IDX_ENTRY, v);
    chk(64'(o_tb_ptr), 64'h0000_0000_0000_0001);
    ipr(0, 1, `XL_IDX_INV_ALL, '0);
    chk(64'(o_tb_ptr), '0);
    results();
  end
endmodule : tb
